// ---- hw/cit_instruction_timing_flags.sv ----
`timescale 1ns/1ps
module cit_instruction_timing_flags (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clkEn,
   input wire logic issue,
   input wire cit_pkg::cit_instr_t instr,
   input wire logic auxCtrlWrite,
   input wire logic [7:0] auxCtrlData,
   output logic busy,
   output logic done,
   output logic [2:0] tStates,
   output cit_pkg::cit_flags_t flags,
   output cit_pkg::cit_result_t result,
   output logic illegal,
   output logic [7:0] auxiliary_control_register
);
   import cit_pkg::*;

   logic [2:0] stateCount;
   logic [2:0] next_stateCount;
   logic [2:0] next_tStates;
   logic next_busy;
   logic next_done;
   logic next_illegal;
   cit_flags_t next_flags;
   cit_result_t next_result;
   logic [7:0] next_aux;
   logic [2:0] needed;
   logic four_state_read_select;
   logic [7:0] xorValue;

   assign four_state_read_select = auxiliary_control_register[FOUR_STATE_READ_BIT];

   always_comb begin
      needed = TS_TWO;
      xorValue = 8'h00;
      next_stateCount = stateCount;
      next_tStates = tStates;
      next_busy = busy;
      next_done = 1'b0;
      next_illegal = 1'b0;
      next_flags = flags;
      next_result = result;
      next_aux = auxiliary_control_register;
      if (auxCtrlWrite) begin
         next_aux = auxCtrlData;
      end
      next_result.regWrite = 1'b0;
      next_result.memWrite = 1'b0;
      case (instr.opClass)
         OP_XOR_ACC, OP_ALU_ACC: needed = instr.toMemory ? TS_THREE : TS_TWO;
         OP_LOAD_MEM: needed = four_state_read_select ? TS_FOUR : TS_THREE;
         OP_COND_BRANCH, OP_FLAG_RETURN: needed = instr.condTrue ? TS_THREE : TS_TWO;
         OP_SHORT_JUMP: needed = TS_THREE;
         OP_REG_JUMP: needed = TS_FOUR;
         OP_LONG_JUMP: needed = TS_FOUR;
         OP_LONG_INDEX_JUMP: needed = TS_TWO;
         OP_MOVE: needed = instr.toMemory ? TS_THREE : TS_TWO;
         OP_BANK_EXCHANGE, OP_TRAP, OP_RETURN: needed = TS_TWO;
         OP_SHIFT: needed = TS_TWO;
         default: needed = TS_TWO;
      endcase
      if (busy) begin
         next_stateCount = stateCount - 3'h1;
         if (stateCount == 3'h1) begin
            next_busy = 1'b0;
            next_done = 1'b1;
         end
      end else if (issue) begin
         next_tStates = needed;
         next_stateCount = needed - 3'h1;
         next_busy = 1'b1;
         next_result.dstReg = instr.dstReg;
         case (instr.opClass)
            OP_XOR_IMM: begin
               if (instr.dstReg > {1'b0, LOW_REG_LIMIT}) begin
                  next_illegal = 1'b1;
               end else begin
                  xorValue = instr.operand ^ instr.aluResult;
                  next_result.data = xorValue;
                  next_result.regWrite = 1'b1;
                  next_flags.n = xorValue[DATA_W-1];
                  next_flags.z = (xorValue == 8'h00);
               end
            end
            OP_XOR_ACC: begin
               xorValue = instr.operand ^ instr.accumulator;
               next_result.data = xorValue;
               next_result.regWrite = !instr.toMemory;
               next_result.memWrite = instr.toMemory;
               next_flags.n = xorValue[DATA_W-1];
               next_flags.z = (xorValue == 8'h00);
            end
            OP_ALU_ACC: begin
               next_result.data = instr.aluResult;
               next_result.regWrite = !instr.toMemory;
               next_result.memWrite = instr.toMemory;
               next_flags = instr.aluFlags;
               next_flags.n = instr.aluResult[DATA_W-1];
               next_flags.z = (instr.aluResult == 8'h00);
            end
            OP_SHIFT: begin
               next_result.data = instr.aluResult;
               next_result.regWrite = 1'b1;
               next_flags.n = instr.aluResult[DATA_W-1];
               next_flags.z = (instr.aluResult == 8'h00);
               next_flags.c = instr.aluFlags.c;
            end
            OP_MOVE: begin
               next_result.data = instr.operand;
               next_result.regWrite = !instr.toMemory;
               next_result.memWrite = instr.toMemory;
            end
            OP_LOAD_MEM: begin
               next_result.data = instr.operand;
               next_result.regWrite = 1'b1;
            end
            OP_RETURN: begin
               if (instr.restoreFlagsOperand) begin
                  next_flags = instr.savedFlags;
               end
            end
            OP_FLAG_RETURN: begin
               if (instr.restoreFlagsOperand && instr.condTrue) begin
                  next_flags = instr.savedFlags;
               end
            end
            default: begin
               next_result.data = result.data;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         stateCount <= 3'h0;
         tStates <= 3'h0;
         busy <= 1'b0;
         done <= 1'b0;
         illegal <= 1'b0;
         flags <= FLAGS_RESET;
         result <= '0;
         auxiliary_control_register <= AUX_CTRL_RESET;
      end else if (clkEn) begin
         stateCount <= next_stateCount;
         tStates <= next_tStates;
         busy <= next_busy;
         done <= next_done;
         illegal <= next_illegal;
         flags <= next_flags;
         result <= next_result;
         auxiliary_control_register <= next_aux;
      end
   end
endmodule

// ---- hw/cit_pkg.sv ----
// What this block does
// - Immediate XOR updates register, flags N Z
// - Immediate XOR names only registers 0-15
// - Accumulator XOR to register or memory
// - Accumulator ops: register 2, memory 3
// - Memory loads take 3, or 4 if set
// - Four-state read select is control bit 3
// - Short call and short jump take 3
// - Register jump and masked relative take 4
// - Long call/jump 2+2; indexed long 2
// - Moves 2 or 3, no flags
// - Exchange, trap, plain return take 2
// - Rotate/shift set N Z C, 2 states
// - Returns restore flags only if operand 1
package cit_pkg;
   localparam int DATA_W = 8;
   localparam int REG_IDX_W = 5;
   localparam logic [3:0] LOW_REG_LIMIT = 4'hf;
   localparam int FOUR_STATE_READ_BIT = 3;
   localparam logic [2:0] TS_TWO = 3'h2;
   localparam logic [2:0] TS_THREE = 3'h3;
   localparam logic [2:0] TS_FOUR = 3'h4;
   localparam logic [3:0] FLAGS_RESET = 4'h0;
   localparam logic [7:0] AUX_CTRL_RESET = 8'h00;

   typedef enum logic [4:0] {
      OP_NOP, OP_XOR_IMM, OP_XOR_ACC, OP_ALU_ACC, OP_LOAD_MEM, OP_COND_BRANCH,
      OP_SHORT_JUMP, OP_REG_JUMP, OP_LONG_JUMP, OP_LONG_INDEX_JUMP, OP_MOVE,
      OP_BANK_EXCHANGE, OP_TRAP, OP_RETURN, OP_FLAG_RETURN, OP_SHIFT
   } cit_class_t;

   typedef struct packed {
      logic n;
      logic z;
      logic c;
      logic v;
   } cit_flags_t;

   typedef struct packed {
      cit_class_t opClass;
      logic [REG_IDX_W-1:0] dstReg;
      logic toMemory;
      logic condTrue;
      logic restoreFlagsOperand;
      logic [7:0] operand;
      logic [7:0] accumulator;
      logic [7:0] aluResult;
      cit_flags_t aluFlags;
      cit_flags_t savedFlags;
   } cit_instr_t;

   typedef struct packed {
      logic [7:0] data;
      logic [REG_IDX_W-1:0] dstReg;
      logic regWrite;
      logic memWrite;
   } cit_result_t;
endpackage

// ---- test/cit_mem_model.sv ----
`timescale 1ns/1ps
module cit_mem_model
   import cit_pkg::*;
(
   input wire logic clk,
   input wire cit_result_t result,
   output logic [7:0] lastWrite
);
   // Keeps only the last stored byte
   always_ff @(posedge clk) begin
      if (result.memWrite) begin
         lastWrite <= result.data;
      end
   end
endmodule

// ---- test/cit_chk.sv ----
`timescale 1ns/1ps
module cit_chk
   import cit_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clkEn,
   input wire logic issue,
   input wire cit_instr_t instr,
   input wire logic auxCtrlWrite,
   input wire logic busy,
   input wire logic done,
   input wire logic [2:0] tStates,
   input wire cit_flags_t flags,
   input wire cit_result_t result,
   input wire logic illegal,
   input wire logic [7:0] auxiliary_control_register
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_take;
      clkEn && issue && !busy;
   endsequence
   a_done_two: assert property (s_take ##1 tStates == TS_TWO |=> done)
      else $error("done late");
   a_done_four: assert property (s_take ##1 tStates == TS_FOUR |=> !done [*2] ##1 done)
      else $error("done off");
   a_xor_reg: assert property (s_take ##0 instr.opClass == OP_XOR_IMM |=>
      tStates == TS_TWO && illegal == $past(instr.dstReg[4])) else $error("xor reg");
   a_xor_flags: assert property (s_take ##0 (instr.opClass == OP_XOR_IMM && !instr.dstReg[4])
      |=> flags.n == result.data[7] && flags.z == (result.data == 8'h00)
      && flags.c == $past(flags.c)) else $error("xor flags");
   a_acc_dest: assert property (s_take ##0 instr.opClass == OP_XOR_ACC |=>
      result.memWrite == $past(instr.toMemory)) else $error("acc dest");
   a_load_time: assert property (s_take ##0 (instr.opClass == OP_LOAD_MEM && !auxCtrlWrite)
      |=> tStates == ($past(auxiliary_control_register[3]) ? TS_FOUR : TS_THREE))
      else $error("load time");
   a_branch_time: assert property (s_take ##0 instr.opClass == OP_COND_BRANCH |=>
      tStates == ($past(instr.condTrue) ? TS_THREE : TS_TWO)) else $error("branch time");
   a_move_flags: assert property (s_take ##0 instr.opClass == OP_MOVE |=> $stable(flags))
      else $error("move flags");
   a_ret_flags: assert property (s_take ##0 (instr.opClass == OP_RETURN
      && !instr.restoreFlagsOperand) |=> $stable(flags)) else $error("ret flags");
endmodule
bind cit_instruction_timing_flags cit_chk i_chk (.clk(clk), .rst_n(rst_n), .clkEn(clkEn),
   .issue(issue), .instr(instr), .auxCtrlWrite(auxCtrlWrite), .busy(busy), .done(done),
   .tStates(tStates), .flags(flags), .result(result), .illegal(illegal),
   .auxiliary_control_register(auxiliary_control_register));

// ---- test/cit_instruction_timing_flags_bench.sv ----
`timescale 1ns/1ps
module cit_instruction_timing_flags_bench;
   import cit_pkg::*;
   typedef struct packed {logic [2:0] ts; logic [7:0] d; logic chk; logic mem;} cit_note_t;
   logic clk = 0, rst_n = 0, issue = 0, auxCtrlWrite = 0, clkEn = 1;
   logic [7:0] auxCtrlData = 8'h00, auxReg, lastWrite;
   cit_instr_t instr = '0;
   logic busy, done, illegal;
   logic [2:0] tStates;
   cit_flags_t flags;
   cit_result_t result;
   cit_note_t notes[$], nt;
   int fails = 0, cmp_count = 0;
   cit_instruction_timing_flags i_dut (.clk(clk), .rst_n(rst_n), .clkEn(clkEn), .issue(issue),
      .instr(instr), .auxCtrlWrite(auxCtrlWrite), .auxCtrlData(auxCtrlData), .busy(busy),
      .done(done), .tStates(tStates), .flags(flags), .result(result), .illegal(illegal),
      .auxiliary_control_register(auxReg));
   cit_mem_model i_mem (.clk(clk), .result(result), .lastWrite(lastWrite));
   initial begin
      forever #12.5 clk = ~clk;
   end
   task automatic cmp8(input string what, input logic [7:0] e, input logic [7:0] s);
      cmp_count++;
      if (s !== e) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, e, s);
      end
   endtask
   task automatic cmp3(input string what, input logic [2:0] e, input logic [2:0] s);
      cmp8(what, {5'h0, e}, {5'h0, s});
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   function automatic logic [2:0] ts_of(input cit_instr_t i, input logic fourRead);
      case (i.opClass)
         OP_XOR_ACC, OP_ALU_ACC, OP_MOVE: return i.toMemory ? TS_THREE : TS_TWO;
         OP_LOAD_MEM: return fourRead ? TS_FOUR : TS_THREE;
         OP_COND_BRANCH, OP_FLAG_RETURN: return i.condTrue ? TS_THREE : TS_TWO;
         OP_SHORT_JUMP: return TS_THREE;
         OP_REG_JUMP, OP_LONG_JUMP: return TS_FOUR;
         default: return TS_TWO;
      endcase
   endfunction
   // Oldest note against each completion
   always @(posedge clk) begin
      #1;
      if (done === 1'b1 && notes.size() > 0) begin
         nt = notes.pop_front();
         cmp3("tStates", nt.ts, tStates);
         if (nt.chk) cmp8("data", nt.d, result.data);
         if (nt.mem) cmp8("memory", nt.d, lastWrite);
      end
   end
   task automatic run(input cit_instr_t i, input logic fourRead);
      int n;
      logic [7:0] d;
      d = (i.opClass == OP_XOR_IMM) ? i.aluResult ^ i.operand : i.operand ^ i.accumulator;
      notes.push_back('{ts_of(i, fourRead), d,
         (i.opClass == OP_XOR_IMM && !i.dstReg[4]) || i.opClass == OP_XOR_ACC,
         i.opClass == OP_XOR_ACC && i.toMemory});
      instr = i;
      issue = 1;
      @(negedge clk);
      issue = 0;
      n = 0;
      while (done !== 1'b1 && n < 10) begin
         @(negedge clk);
         n++;
      end
      if (n == 10) begin
         fails++;
         report_and_stop();
      end
   endtask
   initial begin
      cit_instr_t i;
      logic [63:0] r;
      logic [7:0] a;
      void'($urandom(31));
      repeat (10) @(negedge clk);
      rst_n = 1;
      cmp8("auxReg", 8'h00, auxReg);
      for (int p = 0; p < 2; p++) begin
         a = 8'($urandom);
         a[3] = p[0];
         auxCtrlData = a;
         auxCtrlWrite = 1;
         @(negedge clk);
         auxCtrlWrite = 0;
         cmp8("auxReg", a, auxReg);
         // Every class but OP_NOP, back to back, random fields
         for (int k = 1; k < 16; k++) begin
            repeat (4) begin
               r = {$urandom, $urandom};
               i = r[$bits(cit_instr_t)-1:0];
               i.opClass = cit_class_t'(k);
               if (k == 2) i.aluResult = i.operand ^ i.accumulator;
               run(i, p[0]);
            end
         end
      end
      // Frozen clock enable must hold off a pending issue
      @(negedge clk);
      clkEn = 0;
      i.opClass = OP_SHORT_JUMP;
      instr = i;
      issue = 1;
      repeat (3) @(negedge clk);
      cmp8("busy frozen", 8'h00, {7'h0, busy});
      clkEn = 1;
      run(i, 1'b1);
      repeat (3) @(negedge clk);
      report_and_stop();
   end
endmodule
